// [common/wdt_if.sv]
`timescale 1ns/1ns
// Link between the control side and the timeout counter
interface wdt_if #(parameter int CW = 16);
	logic tick;
	logic kick;
	logic run;
	logic [CW-1:0] limit;
	logic expire;
	logic armed;

	modport ctl (output tick, output kick, output run, output limit, input expire, input armed);
	modport cnt (input tick, input kick, input run, input limit, output expire, output armed);
endinterface

// [common/wdt_map.svh]
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ----------------------------------------
// Register location
// ----------------------------------------
`define WDT_MODE_BANK 4'hF
`define WDT_MODE_ADDR 8'h0F

// ----------------------------------------
// Mode register field positions
// ----------------------------------------
`define WDT_TAP_LSB 0
`define WDT_TAP_MSB 1
`define WDT_HALT_BIT 2
`define WDT_STOP_BIT 3

// ----------------------------------------
// Reset, read and flag values
// ----------------------------------------
`define WDT_TAP_RST 2'h0
`define WDT_HALT_RST 1'b1
`define WDT_STOP_RST 1'b0
`define WDT_READ_VAL 8'hFF
`define WDT_FLAGS_VAL 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDT_TO0_US 5000
`define WDT_TO1_US 10000
`define WDT_TO2_US 20000
`define WDT_TO3_US 80000
`define WDT_RC_KHZ 100
`define WDT_WIN_CRYSTAL_CLOCK 120
`define WDT_SHORT_CLKS 18
`define WDT_POR_TICKS 64

`endif

// [common/wdt_pkg.sv]
package wdt_pkg;

	// Write window of the mode register
	typedef enum logic [1:0] {
		WIN_WAIT,
		WIN_OPEN,
		WIN_LOCKED
	} win_e;

	// Timeout tap select
	typedef logic [1:0] tap_t;

endpackage

// [core/wdt_counter.sv]
`timescale 1ns/1ns
module wdt_counter #(
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control side
	wdt_if.cnt wd
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic armed; // Started by the first kick
		logic [CW-1:0] cnt; // Oscillator ticks since last kick
		logic expire; // One-cycle terminal count pulse
	} cnt_s;

	cnt_s s;
	cnt_s next_s;

	// Count on oscillator ticks, restart on kick
	always_comb begin
		next_s = s;
		next_s.expire = 1'b0;
		if (wd.kick) begin
			next_s.armed = 1'b1;
			next_s.cnt = '0;
		end else if (s.armed && wd.run && wd.tick) begin
			// Compare with >= so a lowered limit still ends the period
			if (s.cnt >= wd.limit - CW'(1)) begin
				next_s.expire = 1'b1;
				next_s.armed = 1'b0;
				next_s.cnt = '0;
			end else begin
				next_s.cnt = s.cnt + CW'(1);
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign wd.expire = s.expire;
	assign wd.armed = s.armed;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_kick_restart: assert property (wd.kick |=> s.cnt == '0 && s.armed)
		else $error("kick did not restart the period");
	a_idle_silent: assert property (!s.armed |=> !s.expire)
		else $error("expiry while disarmed");
	a_tick_only: assert property (!wd.tick && !wd.kick |=> $stable(s.cnt))
		else $error("count moved without a tick");
	a_fire_limit: assert property (s.armed && wd.run && wd.tick && !wd.kick
		&& s.cnt == wd.limit - CW'(1) |=> s.expire)
		else $error("terminal count missed");

endmodule

// [core/wdt_top.sv]
// Functional notes
// - Unrefreshed terminal count resets the core
// - Idle after reset until first kick
// - Each later kick restarts the period
// - Counter runs from the RC oscillator
// - Power-on timer also uses RC oscillator
// - Kick updates zero, sign, overflow flags
// - Bits 1:0 pick 5/10/20/80 ms
// - Bit 2 keeps counting in halt, default one
// - Bit 3 keeps counting in stop
// - Bits 7:4 reserved, no effect
// - Writes accepted for first 120 crystal clocks
// - Then locked until reset or stop recovery
// - Mode register is write only
// - Mode register at bank F, 0Fh
// - Clear-input rising edges start both timers
`timescale 1ns/1ns
`include "wdt_map.svh"
module wdt_top import wdt_pkg::*; #(
	parameter int RC_KHZ = `WDT_RC_KHZ,
	parameter int TICKS0 = (`WDT_TO0_US * RC_KHZ + 999) / 1000,
	parameter int TICKS1 = (`WDT_TO1_US * RC_KHZ + 999) / 1000,
	parameter int TICKS2 = (`WDT_TO2_US * RC_KHZ + 999) / 1000,
	parameter int TICKS3 = (`WDT_TO3_US * RC_KHZ + 999) / 1000,
	parameter int POR_TICKS = `WDT_POR_TICKS,
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Oscillator and clear pins
	input wire logic rc_osc_in,
	input wire logic por_timer_clear_in,
	input wire logic short_reset_timer_clear_in,
	// Core status
	input wire logic first_instr,
	input wire logic watchdog_kick_instruction,
	input wire logic halt_mode,
	input wire logic stop_mode,
	input wire logic stop_recover,
	// Register port
	input wire logic [3:0] reg_bank,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Results
	output logic cpu_reset,
	output logic flags_we,
	output logic [2:0] flags_zsv,
	output logic wdt_armed,
	output logic por_busy,
	output logic short_reset_busy
);

	localparam int PW = $clog2(POR_TICKS + 1);
	localparam int WW = $clog2(`WDT_WIN_CRYSTAL_CLOCK + 1);
	localparam int SW = $clog2(`WDT_SHORT_CLKS + 1);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic rc1; // Oscillator synchroniser, first stage
		logic rc2; // Second stage
		logic rc3; // Edge history
		logic p1; // Power-on clear synchroniser
		logic p2;
		logic p3;
		logic q1; // Short reset clear synchroniser
		logic q2;
		logic q3;
		tap_t tap; // Timeout select
		logic halt_en; // Count during halt
		logic stop_en; // Count during stop
		win_e win; // Write window phase
		logic [WW-1:0] win_cnt; // Crystal clocks into the window
		logic fire; // Core reset pulse
		logic flags_we; // Flag update strobe
		logic [2:0] flags; // Flag values
		logic [7:0] rdata; // Read data
		logic [PW-1:0] por_cnt; // Power-on timer
		logic por_busy;
		logic [SW-1:0] sh_cnt; // Short reset timer
		logic sh_busy;
	} top_s;

	top_s s;
	top_s next_s;
	logic rc_tick;
	logic mode_wr;
	logic mode_rd;

	wdt_if #(.CW(CW)) wd ();

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	// True when the port points at the mode register
	function automatic logic mode_hit(input logic [3:0] bank, input logic [7:0] addr);
		return bank == `WDT_MODE_BANK && addr == `WDT_MODE_ADDR;
	endfunction

	// Terminal count for each tap
	function automatic logic [CW-1:0] tap_limit(input tap_t tap);
		case (tap)
			2'h0: return CW'(TICKS0);
			2'h1: return CW'(TICKS1);
			2'h2: return CW'(TICKS2);
			default: return CW'(TICKS3);
		endcase
	endfunction

	assign mode_wr = reg_wr && mode_hit(reg_bank, reg_addr);
	assign mode_rd = reg_rd && mode_hit(reg_bank, reg_addr);
	assign rc_tick = s.rc2 && !s.rc3;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		// Pins pass two flops before any logic sees them
		next_s.rc1 = rc_osc_in;
		next_s.rc2 = s.rc1;
		next_s.rc3 = s.rc2;
		next_s.p1 = por_timer_clear_in;
		next_s.p2 = s.p1;
		next_s.p3 = s.p2;
		next_s.q1 = short_reset_timer_clear_in;
		next_s.q2 = s.q1;
		next_s.q3 = s.q2;
		next_s.fire = 1'b0;
		next_s.flags_we = 1'b0;

		// Window and mode register
		if (wd.expire) begin
			next_s.fire = 1'b1;
			next_s.tap = `WDT_TAP_RST;
			next_s.halt_en = `WDT_HALT_RST;
			next_s.stop_en = `WDT_STOP_RST;
			next_s.win = WIN_WAIT;
		end else if (stop_recover) begin
			// Recovery reopens the window but keeps the settings
			next_s.win = WIN_WAIT;
		end else begin
			case (s.win)
				WIN_WAIT: begin
					if (first_instr) begin
						next_s.win = WIN_OPEN;
						next_s.win_cnt = '0;
					end
				end
				WIN_OPEN: begin
					if (mode_wr) begin
						next_s.tap = reg_wdata[`WDT_TAP_MSB:`WDT_TAP_LSB];
						next_s.halt_en = reg_wdata[`WDT_HALT_BIT];
						next_s.stop_en = reg_wdata[`WDT_STOP_BIT];
						// Upper bits are dropped here
					end
					if (s.win_cnt == WW'(`WDT_WIN_CRYSTAL_CLOCK - 1)) begin
						next_s.win = WIN_LOCKED;
					end else begin
						next_s.win_cnt = s.win_cnt + WW'(1);
					end
				end
				WIN_LOCKED: begin
					// Writes have no path here
				end
				default: begin
					next_s.win = WIN_WAIT;
				end
			endcase
		end

		// Flag update from the kick instruction
		if (watchdog_kick_instruction) begin
			next_s.flags_we = 1'b1;
			next_s.flags = `WDT_FLAGS_VAL;
		end

		// Reads never reveal the mode setting
		next_s.rdata = mode_rd ? `WDT_READ_VAL : 8'h00;

		// Power-on timer on oscillator ticks
		if (s.p2 && !s.p3) begin
			next_s.por_cnt = PW'(POR_TICKS);
		end else if (rc_tick && s.por_cnt != '0) begin
			next_s.por_cnt = s.por_cnt - PW'(1);
		end
		next_s.por_busy = next_s.por_cnt != '0;

		// Short reset timer on crystal clocks
		if (s.q2 && !s.q3) begin
			next_s.sh_cnt = SW'(`WDT_SHORT_CLKS);
		end else if (s.sh_cnt != '0) begin
			next_s.sh_cnt = s.sh_cnt - SW'(1);
		end
		next_s.sh_busy = next_s.sh_cnt != '0;
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.tap <= `WDT_TAP_RST;
			s.halt_en <= `WDT_HALT_RST;
			s.stop_en <= `WDT_STOP_RST;
			s.win <= WIN_WAIT;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Counter and outputs
	// ----------------------------------------
	assign wd.tick = rc_tick;
	assign wd.kick = watchdog_kick_instruction;
	assign wd.limit = tap_limit(s.tap);
	// Halt and stop gate the count only when the setting says so
	assign wd.run = (!halt_mode || s.halt_en) && (!stop_mode || s.stop_en);

	wdt_counter #(.CW(CW)) u_counter (
		.clk(clk),
		.rst(rst),
		.wd(wd)
	);

	assign cpu_reset = s.fire;
	assign flags_we = s.flags_we;
	assign flags_zsv = s.flags;
	assign wdt_armed = wd.armed;
	assign reg_rdata = s.rdata;
	assign por_busy = s.por_busy;
	assign short_reset_busy = s.sh_busy;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_expire_reset: assert property (wd.expire |=> cpu_reset)
		else $error("core reset not raised");
	a_reset_default: assert property (wd.expire |=> s.halt_en
		&& s.tap == `WDT_TAP_RST && s.win == WIN_WAIT)
		else $error("defaults not restored");
	a_locked_mode: assert property (s.win == WIN_LOCKED && !wd.expire
		|=> $stable(s.tap) && $stable(s.halt_en) && $stable(s.stop_en))
		else $error("locked mode register changed");
	a_window_len: assert property (s.win == WIN_OPEN |-> s.win_cnt < WW'(`WDT_WIN_CRYSTAL_CLOCK))
		else $error("window overran");
	a_open_write: assert property (s.win == WIN_OPEN && mode_wr
		&& !wd.expire && !stop_recover |=> s.tap == $past(reg_wdata[1:0]))
		else $error("window write lost");
	a_read_hidden: assert property (mode_rd |=> reg_rdata == `WDT_READ_VAL)
		else $error("mode read leaked");
	a_kick_flags: assert property (watchdog_kick_instruction |=> flags_we)
		else $error("flags not updated");
	a_short_len: assert property (s.q2 && !s.q3 |=> short_reset_busy[*8])
		else $error("short reset too short");
	a_short_max: assert property (s.sh_cnt <= SW'(`WDT_SHORT_CLKS))
		else $error("short reset count overran");
	a_halt_stall: assert property (halt_mode && !s.halt_en && !stop_mode |-> !wd.run)
		else $error("count ran in halt");

endmodule

// [tb/tb_wdt_top.sv]
`timescale 1ns/1ns
module tb_wdt_top;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rc_osc_in = 1'b0;
	logic por_timer_clear_in = 1'b0;
	logic short_reset_timer_clear_in = 1'b0;
	logic first_instr = 1'b0;
	logic watchdog_kick_instruction = 1'b0;
	logic halt_mode = 1'b0;
	logic stop_mode = 1'b0;
	logic stop_recover = 1'b0;
	logic [3:0] reg_bank = 4'h0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic cpu_reset;
	logic flags_we;
	logic [2:0] flags_zsv;
	logic wdt_armed;
	logic por_busy;
	logic short_reset_busy;
	logic [1:0] rc_div = 2'h0; // Slow oscillator divider
	int mismatches = 0;
	int checks = 0;

	// Short tap counts keep the run brief, each twice the last
	wdt_top #(.TICKS0(4), .TICKS1(8), .TICKS2(16), .TICKS3(32), .POR_TICKS(4)) wdt_top_inst (
		.clk, .rst, .rc_osc_in, .por_timer_clear_in, .short_reset_timer_clear_in,
		.first_instr, .watchdog_kick_instruction, .halt_mode, .stop_mode, .stop_recover,
		.reg_bank, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.cpu_reset, .flags_we, .flags_zsv, .wdt_armed, .por_busy, .short_reset_busy
	);

	// ----------------------------------------
	// Clocks
	// ----------------------------------------
	always #10 clk = ~clk;

	// Oscillator at a quarter of the clock, phase unrelated to kicks
	always @(negedge clk) begin
		rc_div <= rc_div + 2'h1;
		rc_osc_in <= rc_div[1];
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function int tk(input int i);
		return 4 << i;
	endfunction

	task step(input int n);
		repeat (n) @(negedge clk);
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task wr(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
		reg_bank = b;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step(1);
		reg_wr = 1'b0;
		// Let an edge pass so a following write raises the strobe anew
		step(1);
	endtask

	// Read data stands one cycle only, so it is taken right away
	task rd(input logic [3:0] b, input logic [7:0] a, input logic [7:0] exp);
		reg_bank = b;
		reg_addr = a;
		reg_rd = 1'b1;
		step(1);
		reg_rd = 1'b0;
		chk(reg_rdata, exp, "read data");
		// Idle edge between back-to-back reads
		step(1);
	endtask

	task open_win;
		first_instr = 1'b1;
		step(1);
		first_instr = 1'b0;
	endtask

	// Flag pulse may land one or two edges late; exactly one is wanted
	task kick;
		int n;
		n = 0;
		watchdog_kick_instruction = 1'b1;
		step(1);
		watchdog_kick_instruction = 1'b0;
		repeat (3) begin
			if (flags_we === 1'b1 && flags_zsv === 3'h0) n++;
			step(1);
		end
		chk(8'(n), 8'h01, "kick flags");
		chk({7'h0, wdt_armed}, 8'h01, "armed");
	endtask

	// Window allows for synchroniser and oscillator phase
	task fire(input int t);
		int n;
		n = 0;
		while (cpu_reset !== 1'b1 && n < 4 * t + 5) begin
			step(1);
			n++;
		end
		chk(8'(n >= 4 * t - 6 && n <= 4 * t + 4), 8'h01, "timeout length");
		step(2);
	endtask

	task quiet(input int n);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			if (cpu_reset !== 1'b0) bad = 1'b1;
			step(1);
		end
		chk({7'h0, bad}, 8'h00, "unexpected core reset");
	endtask

	task pulse_count(input logic which, output int n);
		n = 0;
		if (which) short_reset_timer_clear_in = 1'b1;
		else por_timer_clear_in = 1'b1;
		repeat (60) begin
			if ((which ? short_reset_busy : por_busy) === 1'b1) n++;
			step(1);
		end
		// Only the raised pin drops, so the next call drives a fresh edge
		if (which) short_reset_timer_clear_in = 1'b0;
		else por_timer_clear_in = 1'b0;
	endtask

	task test_done;
		if (mismatches == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int n;
		step(4);
		rst = 1'b0;
		chk({7'h0, wdt_armed}, 8'h00, "armed idle");
		quiet(200);
		// Every tap, reserved bits set; each expiry restores defaults
		for (int i = 0; i < 4; i++) begin
			open_win;
			wr(4'hF, 8'h0F, 8'hF0 | 8'(i));
			kick;
			fire(tk(i));
		end
		wr(4'hF, 8'h0F, 8'h03);
		kick;
		fire(tk(0));
		// Refresh faster than the shortest timeout
		kick;
		repeat (8) begin
			quiet(3);
			kick;
		end
		fire(tk(0));
		// Wrong place and late write are both dropped
		open_win;
		wr(4'hE, 8'h0F, 8'h03);
		wr(4'hF, 8'h0E, 8'h03);
		step(125);
		wr(4'hF, 8'h0F, 8'h03);
		kick;
		fire(tk(0));
		// Stop recovery unlocks a closed window
		open_win;
		step(125);
		stop_recover = 1'b1;
		step(1);
		stop_recover = 1'b0;
		open_win;
		wr(4'hF, 8'h0F, 8'h01);
		kick;
		fire(tk(1));
		// Halt with counting disabled, then default enabled
		open_win;
		wr(4'hF, 8'h0F, 8'h00);
		halt_mode = 1'b1;
		kick;
		quiet(200);
		halt_mode = 1'b0;
		fire(tk(0));
		halt_mode = 1'b1;
		kick;
		fire(tk(0));
		halt_mode = 1'b0;
		// Stop paused by default, counting once enabled
		stop_mode = 1'b1;
		kick;
		quiet(200);
		stop_mode = 1'b0;
		fire(tk(0));
		open_win;
		wr(4'hF, 8'h0F, 8'h08);
		stop_mode = 1'b1;
		kick;
		fire(tk(0));
		stop_mode = 1'b0;
		rd(4'hF, 8'h0F, 8'hFF);
		rd(4'hF, 8'h0E, 8'h00);
		pulse_count(1'b1, n);
		chk(8'(n), 8'h12, "short timer");
		pulse_count(1'b0, n);
		chk(8'(n >= 12 && n <= 20), 8'h01, "power-on timer");
		test_done;
	end

	// Whole run is under two thousand cycles; far beyond that is a hang
	initial begin
		#400000;
		mismatches++;
		$display("mismatch %0t run timed out", $time);
		test_done;
	end
endmodule
